// File: include/seq_pkg.sv
// shared constants and types for the program sequencer and addressing block
package seq_pkg;
  localparam int PC_W    = 11;
  localparam int PAGE_W  = 5;
  localparam int OFFS_W  = 6;
  localparam int TP_W    = 12;
  localparam int WORD_W  = 4;
  localparam int RAM_AW  = 7;
  localparam int RAM_WORDS = 128;

  localparam logic [10:0] RESET_ADDR       = 11'h000;
  localparam logic [10:0] SEQ_STEP         = 11'h001;
  localparam logic [10:0] LONG_BRANCH_STEP = 11'h002;
  localparam logic [10:0] PROG_MASK_SMALL  = 11'h3FF;
  localparam logic [10:0] PROG_MASK_LARGE  = 11'h7FF;
  localparam logic [6:0]  RAM_MASK_SMALL   = 7'h3F;
  localparam logic [6:0]  RAM_MASK_LARGE   = 7'h7F;

  // data memory special words, large-variant addresses
  localparam logic [7:0] STACK_BASE_ADDR = 8'h40;
  localparam logic [7:0] SELECTOR_ADDR   = 8'h7F;
  localparam logic [7:0] TABLE_PTR_ADDR  = 8'h7C;
  localparam logic [7:0] TIMER1_ADDR     = 8'h74;
  localparam logic [7:0] TIMER2_ADDR     = 8'h78;
  localparam logic [7:0] ZERO_PAGE_MASK  = 8'h0F;

  // word offsets inside one four-word stack location
  localparam logic [7:0] SLOT_ADDR_LOW   = 8'h00;
  localparam logic [7:0] SLOT_ADDR_MID   = 8'h01;
  localparam logic [7:0] SLOT_ADDR_HIGH  = 8'h02;
  localparam logic [7:0] SLOT_FLAGS      = 8'h03;

  localparam logic [3:0] NIBBLE_ONE      = 4'h1;

  typedef enum logic [11:0] {
    OP_NONE              = 12'h001,
    OP_LONG_BRANCH       = 12'h002,
    OP_IN_PAGE_BRANCH    = 12'h004,
    OP_CALL              = 12'h008,
    OP_SUB_RETURN        = 12'h010,
    OP_INT_RETURN        = 12'h020,
    OP_TABLE_READ_LOW    = 12'h040,
    OP_TABLE_READ_HIGH   = 12'h080,
    OP_LOAD_POINTER_PAIR = 12'h100,
    OP_MEM_READ          = 12'h200,
    OP_MEM_WRITE         = 12'h400,
    OP_PORT_BIT          = 12'h800
  } op_type;

  typedef enum logic [2:0] {
    MODE_INDIRECT  = 3'h1,
    MODE_DIRECT    = 3'h2,
    MODE_ZERO_PAGE = 3'h4
  } addr_mode_type;

  typedef enum logic [2:0] {
    STEP_NONE = 3'h1,
    STEP_INC  = 3'h2,
    STEP_DEC  = 3'h4
  } step_type;
endpackage

// File: hdl/program_sequencer.sv
// program sequencer, table look-up and data memory addressing of the 4-bit core
`timescale 1ns/1ps

// Function
// - 11-bit pointer advances by instruction length
// - reset forces instruction pointer to zero
// - five page bits, six in-page bits
// - taken in-page branch loads six low bits
// - last-address branch lands in next page
// - long branch: load target or add 2
// - untaken in-page branch adds one
// - returns reload pointer from stack
// - interrupt loads vector, upper bits zero
// - 12-bit table pointer spans program memory
// - table reads give low or high nibble
// - high nibble read increments table pointer
// - small variant ignores address top bit
// - page and word registers form pointer
// - word register post-steps after transfer
// - word register selects port bit
// - direct mode uses second byte, top bit ignored
// - zero-page mode uses low four bits
// - data memory 64 or 128 nibbles
// - timer counts share stack locations 13, 14
// - interrupt return also restores flags
// - selector decrements after save, increments before restore
// - table pointer lives in three memory words
module program_sequencer #(
  parameter bit SMALL_VARIANT = 1'b0
) (
  input  wire logic                  clk_sys_in,
  input  wire logic                  reset_n_in,
  input  wire logic                  instr_valid_in,
  input  wire seq_pkg::op_type       instr_op_in,
  input  wire logic [1:0]            instr_len_in,
  input  wire logic [10:0]           instr_imm_in,
  input  wire logic [7:0]            instr_byte2_in,
  input  wire seq_pkg::addr_mode_type instr_mode_in,
  input  wire seq_pkg::step_type     instr_step_in,
  input  wire logic                  branch_condition_flag_in,
  input  wire logic                  int_accept_in,
  input  wire logic [5:0]            int_vector_in,
  input  wire logic [3:0]            flags_in,
  input  wire logic [3:0]            acc_in,
  input  wire logic [7:0]            table_data_in,
  input  wire logic                  first_timer_wr_in,
  input  wire logic [11:0]           first_timer_value_in,
  input  wire logic                  second_timer_wr_in,
  input  wire logic [11:0]           second_timer_value_in,
  output logic      [10:0]           prog_addr_out,
  output logic      [10:0]           table_addr_out,
  output logic                       acc_load_out,
  output logic      [3:0]            acc_data_out,
  output logic                       flags_restore_out,
  output logic      [3:0]            flags_data_out,
  output logic      [3:0]            page_select_out,
  output logic      [3:0]            word_select_out,
  output logic                       port_bit_strobe_out,
  output logic      [3:0]            port_bit_select_out,
  output logic      [11:0]           first_timer_count_out,
  output logic      [11:0]           second_timer_count_out
);
  import seq_pkg::*;

  logic [10:0] instruction_pointer;
  logic [10:0] next_instruction_pointer;
  logic [3:0]  page_select;
  logic [3:0]  word_select;
  logic [3:0]  data_mem [0:RAM_WORDS-1];
  logic [10:0] prog_mask;
  logic [10:0] seq_addr;
  logic [10:0] step_one_addr;
  logic [10:0] in_page_target;
  logic [3:0]  stack_location_selector;
  logic [3:0]  restore_location;
  logic [7:0]  save_base;
  logic [7:0]  restore_base;
  logic [10:0] restored_addr;
  logic [3:0]  restored_flags;
  logic [10:0] saved_addr;
  logic [11:0] table_pointer;
  logic [11:0] next_table_pointer;
  logic [6:0]  mem_index;
  logic        do_exec;
  logic        do_save;
  logic        do_restore;
  logic [11:0] restored_triple;
  logic        take_mem_write;
  logic        take_mem_read;
  logic        take_table_high;
  logic        take_int_return;
  logic        take_port_bit;
  logic        take_pair_load;

  // index wraps at 64 or 128 words
  function automatic logic [6:0] ram_index(input logic [7:0] addr);
    ram_index = addr[6:0] & (SMALL_VARIANT ? RAM_MASK_SMALL : RAM_MASK_LARGE);
  endfunction

  // first word of a four-word stack location
  function automatic logic [7:0] stack_base(input logic [3:0] location);
    stack_base = STACK_BASE_ADDR + {2'b00, location, 2'b00};
  endfunction

  function automatic logic [6:0] data_address(input addr_mode_type mode,
                                              input logic [7:0]    byte2,
                                              input logic [3:0]    page,
                                              input logic [3:0]    word);
    unique case (mode)
      MODE_DIRECT:    data_address = ram_index(byte2);
      MODE_ZERO_PAGE: data_address = ram_index(byte2 & ZERO_PAGE_MASK);
      MODE_INDIRECT:  data_address = ram_index({page, word});
      default:        data_address = ram_index({page, word});
    endcase
  endfunction

  function automatic logic [11:0] read_triple(input logic [7:0] base);
    read_triple = {data_mem[ram_index(base + SLOT_ADDR_HIGH)],
                   data_mem[ram_index(base + SLOT_ADDR_MID)],
                   data_mem[ram_index(base + SLOT_ADDR_LOW)]};
  endfunction

  // small variant keeps ten program address bits
  assign prog_mask = SMALL_VARIANT ? PROG_MASK_SMALL : PROG_MASK_LARGE;

  // interrupt takes precedence over the instruction
  assign do_exec    = instr_valid_in & ~int_accept_in;
  assign do_save    = int_accept_in | (do_exec & (instr_op_in == OP_CALL));
  assign do_restore = do_exec & ((instr_op_in == OP_SUB_RETURN) |
                                 (instr_op_in == OP_INT_RETURN));

  // decoded strobes for instructions that really execute
  assign take_mem_write  = do_exec & (instr_op_in == OP_MEM_WRITE);
  assign take_mem_read   = do_exec & (instr_op_in == OP_MEM_READ);
  assign take_table_high = do_exec & (instr_op_in == OP_TABLE_READ_HIGH);
  assign take_int_return = do_exec & (instr_op_in == OP_INT_RETURN);
  assign take_port_bit   = do_exec & (instr_op_in == OP_PORT_BIT);
  assign take_pair_load  = do_exec & (instr_op_in == OP_LOAD_POINTER_PAIR);

  assign seq_addr      = instruction_pointer + {9'h000, instr_len_in};
  assign step_one_addr = instruction_pointer + SEQ_STEP;
  // page bits come from the address after the branch byte
  assign in_page_target = {step_one_addr[PC_W-1:OFFS_W], instr_imm_in[OFFS_W-1:0]};

  // selector word is not reset; software sets it before any call
  // selector names the location of the next save
  assign stack_location_selector = data_mem[ram_index(SELECTOR_ADDR)];
  assign restore_location        = stack_location_selector + NIBBLE_ONE;
  assign save_base               = stack_base(stack_location_selector);
  assign restore_base            = stack_base(restore_location);
  assign restored_addr           = restored_triple[10:0];
  assign restored_flags          = data_mem[ram_index(restore_base + SLOT_FLAGS)];
  // an interrupt saves the address it kept from executing
  // call saves the address of the following instruction
  assign saved_addr = int_accept_in ? instruction_pointer : seq_addr;

  // table pointer held low nibble first
  assign next_table_pointer = table_pointer + 12'h001;

  // function reads of memory words are not seen by a continuous assign,
  // so the three-word values are gathered in a process that sees them
  always_comb begin
    restored_triple        = read_triple(restore_base);
    table_pointer          = read_triple(TABLE_PTR_ADDR);
    // timer counts read back from shared words
    first_timer_count_out  = read_triple(TIMER1_ADDR);
    second_timer_count_out = read_triple(TIMER2_ADDR);
  end

  assign mem_index = data_address(instr_mode_in, instr_byte2_in, page_select, word_select);

  always_comb begin
    next_instruction_pointer = seq_addr;
    if (int_accept_in) begin
      next_instruction_pointer = {5'h00, int_vector_in};
    end else if (instr_valid_in) begin
      unique case (instr_op_in)
        OP_LONG_BRANCH: begin
          // full target or skip two bytes
          next_instruction_pointer = branch_condition_flag_in ? instr_imm_in
                                     : instruction_pointer + LONG_BRANCH_STEP;
        end
        OP_IN_PAGE_BRANCH: begin
          next_instruction_pointer = branch_condition_flag_in ? in_page_target
                                     : step_one_addr;
        end
        OP_CALL: begin
          // full target after return is saved
          next_instruction_pointer = instr_imm_in;
        end
        OP_SUB_RETURN, OP_INT_RETURN: begin
          next_instruction_pointer = restored_addr;
        end
        default: begin
          next_instruction_pointer = seq_addr;
        end
      endcase
    end else begin
      next_instruction_pointer = instruction_pointer;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      instruction_pointer <= RESET_ADDR;
    end else begin
      instruction_pointer <= next_instruction_pointer;
    end
  end

  // top address bit dropped on the small variant
  assign prog_addr_out  = instruction_pointer & prog_mask;
  assign table_addr_out = table_pointer[10:0] & prog_mask;

  // data memory: contents are undefined after power-up, so no reset
  always_ff @(posedge clk_sys_in) begin
    if (do_save) begin
      data_mem[ram_index(save_base + SLOT_ADDR_LOW)]  <= saved_addr[3:0];
      data_mem[ram_index(save_base + SLOT_ADDR_MID)]  <= saved_addr[7:4];
      data_mem[ram_index(save_base + SLOT_ADDR_HIGH)] <= {1'b0, saved_addr[10:8]};
      // a call never writes the flags word
      if (int_accept_in) begin
        data_mem[ram_index(save_base + SLOT_FLAGS)] <= flags_in;
      end
      data_mem[ram_index(SELECTOR_ADDR)] <= stack_location_selector - NIBBLE_ONE;
    end else if (do_restore) begin
      data_mem[ram_index(SELECTOR_ADDR)] <= restore_location;
    end else if (take_mem_write) begin
      data_mem[mem_index] <= acc_in;
    end else if (take_table_high) begin
      data_mem[ram_index(TABLE_PTR_ADDR + SLOT_ADDR_LOW)]  <= next_table_pointer[3:0];
      data_mem[ram_index(TABLE_PTR_ADDR + SLOT_ADDR_MID)]  <= next_table_pointer[7:4];
      data_mem[ram_index(TABLE_PTR_ADDR + SLOT_ADDR_HIGH)] <= next_table_pointer[11:8];
    end
    // timer writes come last so they win over instruction writes
    // timer counts land in stack locations 13 and 14
    if (first_timer_wr_in) begin
      data_mem[ram_index(TIMER1_ADDR + SLOT_ADDR_LOW)]  <= first_timer_value_in[3:0];
      data_mem[ram_index(TIMER1_ADDR + SLOT_ADDR_MID)]  <= first_timer_value_in[7:4];
      data_mem[ram_index(TIMER1_ADDR + SLOT_ADDR_HIGH)] <= first_timer_value_in[11:8];
    end
    if (second_timer_wr_in) begin
      data_mem[ram_index(TIMER2_ADDR + SLOT_ADDR_LOW)]  <= second_timer_value_in[3:0];
      data_mem[ram_index(TIMER2_ADDR + SLOT_ADDR_MID)]  <= second_timer_value_in[7:4];
      data_mem[ram_index(TIMER2_ADDR + SLOT_ADDR_HIGH)] <= second_timer_value_in[11:8];
    end
  end

  // accumulator load path
  // table byte answers the table address within the same cycle
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      acc_load_out <= 1'b0;
      acc_data_out <= 4'h0;
    end else begin
      acc_load_out <= 1'b0;
      if (do_exec) begin
        unique case (instr_op_in)
          OP_TABLE_READ_LOW: begin
            acc_load_out <= 1'b1;
            acc_data_out <= table_data_in[3:0];
          end
          OP_TABLE_READ_HIGH: begin
            acc_load_out <= 1'b1;
            acc_data_out <= table_data_in[7:4];
          end
          OP_MEM_READ: begin
            acc_load_out <= 1'b1;
            acc_data_out <= data_mem[mem_index];
          end
          default: begin
            acc_load_out <= 1'b0;
          end
        endcase
      end
    end
  end

  // flags restored only by interrupt return
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flags_restore_out <= 1'b0;
      flags_data_out    <= 4'h0;
    end else begin
      flags_restore_out <= take_int_return;
      if (take_int_return) begin
        flags_data_out <= restored_flags;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      page_select <= 4'h0;
      word_select <= 4'h0;
    end else if (take_pair_load) begin
      page_select <= instr_byte2_in[7:4];
      word_select <= instr_byte2_in[3:0];
    end else if (take_mem_read || take_mem_write) begin
      // step after the transfer used the old value
      unique case (instr_step_in)
        STEP_INC:  word_select <= word_select + NIBBLE_ONE;
        STEP_DEC:  word_select <= word_select - NIBBLE_ONE;
        STEP_NONE: word_select <= word_select;
        default:   word_select <= word_select;
      endcase
    end
  end

  assign page_select_out = page_select;
  assign word_select_out = word_select;

  // port bit chosen by word register
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      port_bit_strobe_out <= 1'b0;
      port_bit_select_out <= 4'h0;
    end else begin
      port_bit_strobe_out <= take_port_bit;
      if (take_port_bit) begin
        port_bit_select_out <= word_select;
      end
    end
  end
endmodule

// File: dv/program_sequencer_properties.sv
// assertion checker bound to the program sequencer
`timescale 1ns/1ps
module program_sequencer_properties #(
  parameter bit SMALL_VARIANT = 1'b0
) (
  input wire logic              clk_sys_in,
  input wire logic              reset_n_in,
  input wire logic              instr_valid_in,
  input wire seq_pkg::op_type   instr_op_in,
  input wire logic [1:0]        instr_len_in,
  input wire logic [10:0]       instr_imm_in,
  input wire seq_pkg::step_type instr_step_in,
  input wire logic              branch_condition_flag_in,
  input wire logic              int_accept_in,
  input wire logic [5:0]        int_vector_in,
  input wire logic [7:0]        table_data_in,
  input wire logic [10:0]       prog_addr_out,
  input wire logic [10:0]       table_addr_out,
  input wire logic              acc_load_out,
  input wire logic [3:0]        acc_data_out,
  input wire logic              flags_restore_out,
  input wire logic [3:0]        word_select_out,
  input wire logic              port_bit_strobe_out,
  input wire logic [3:0]        port_bit_select_out
);
  import seq_pkg::*;
  logic [10:0] msk;
  logic [10:0] nxt;
  logic        tk;
  assign msk = SMALL_VARIANT ? PROG_MASK_SMALL : PROG_MASK_LARGE;
  assign nxt = (prog_addr_out + SEQ_STEP) & msk;
  // instruction taken unless an interrupt steals the cycle
  assign tk = instr_valid_in && !int_accept_in;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);
  sequence s_call;
    tk && instr_op_in == OP_CALL;
  endsequence
  sequence s_ret;
    tk && instr_op_in == OP_SUB_RETURN;
  endsequence
  AST_RESET_ZERO: assert property ($rose(reset_n_in) |-> prog_addr_out == RESET_ADDR)
    else $error("pointer not zero after reset");
  AST_IDLE_HOLD: assert property (!instr_valid_in && !int_accept_in |=> $stable(prog_addr_out))
    else $error("pointer moved while idle");
  AST_SEQ_STEP: assert property (tk && !(instr_op_in inside {OP_LONG_BRANCH, OP_IN_PAGE_BRANCH,
    OP_CALL, OP_SUB_RETURN, OP_INT_RETURN}) |=> prog_addr_out ==
    (($past(prog_addr_out) + {9'h000, $past(instr_len_in)}) & msk))
    else $error("sequential step wrong");
  AST_LONG_BRANCH: assert property (tk && instr_op_in == OP_LONG_BRANCH |=> prog_addr_out ==
    ($past(branch_condition_flag_in) ? ($past(instr_imm_in) & msk) :
    (($past(prog_addr_out) + LONG_BRANCH_STEP) & msk)))
    else $error("long branch target wrong");
  AST_PAGE_TAKEN: assert property (tk && instr_op_in == OP_IN_PAGE_BRANCH &&
    branch_condition_flag_in |=> prog_addr_out == {$past(nxt[10:6]), $past(instr_imm_in[5:0])})
    else $error("in-page branch target wrong");
  AST_PAGE_SKIP: assert property (tk && instr_op_in == OP_IN_PAGE_BRANCH &&
    !branch_condition_flag_in |=> prog_addr_out == $past(nxt))
    else $error("untaken in-page branch wrong");
  AST_CALL_TARGET: assert property (s_call |=> prog_addr_out == ($past(instr_imm_in) & msk))
    else $error("call target wrong");
  AST_CALL_RETURN: assert property (s_call ##1 s_ret |=> prog_addr_out ==
    (($past(prog_addr_out, 2) + {9'h000, $past(instr_len_in, 2)}) & msk))
    else $error("return address wrong");
  AST_VECTOR: assert property (int_accept_in |=> prog_addr_out == {5'h00, $past(int_vector_in)})
    else $error("interrupt vector wrong");
  AST_TABLE_HIGH: assert property (tk && instr_op_in == OP_TABLE_READ_HIGH |=> acc_load_out &&
    acc_data_out == $past(table_data_in[7:4]) &&
    table_addr_out == (($past(table_addr_out) + SEQ_STEP) & msk))
    else $error("high nibble table read wrong");
  AST_FLAG_RESTORE: assert property (tk && instr_op_in inside {OP_SUB_RETURN, OP_INT_RETURN}
    |=> flags_restore_out == $past(instr_op_in == OP_INT_RETURN))
    else $error("flag restore wrong");
  AST_WORD_STEP: assert property (tk && instr_op_in inside {OP_MEM_READ, OP_MEM_WRITE} &&
    instr_step_in != STEP_NONE |=> word_select_out == $past(word_select_out) +
    ($past(instr_step_in) == STEP_INC ? NIBBLE_ONE : 4'hF))
    else $error("word register step wrong");
  AST_PORT_BIT: assert property (tk && instr_op_in == OP_PORT_BIT |=> port_bit_strobe_out &&
    port_bit_select_out == $past(word_select_out))
    else $error("port bit select wrong");
endmodule

bind program_sequencer program_sequencer_properties #(
  .SMALL_VARIANT(SMALL_VARIANT)
) i_program_sequencer_properties (
  .clk_sys_in, .reset_n_in, .instr_valid_in, .instr_op_in, .instr_len_in, .instr_imm_in,
  .instr_step_in, .branch_condition_flag_in, .int_accept_in, .int_vector_in, .table_data_in,
  .prog_addr_out, .table_addr_out, .acc_load_out, .acc_data_out, .flags_restore_out,
  .word_select_out, .port_bit_strobe_out, .port_bit_select_out
);

// File: dv/program_memory_model.sv
// program memory model answering table look-up addresses
`timescale 1ns/1ps
module program_memory_model (
  input  wire logic [10:0] table_addr_in,
  output logic      [7:0]  table_data_out
);
  // byte is low address byte XORed with top three address bits over 5'h0A
  assign table_data_out = table_addr_in[7:0] ^ {table_addr_in[10:8], 5'h0A};
endmodule

// File: dv/program_sequencer_test.sv
// self-checking bench of the program sequencer
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module program_sequencer_test;
  import seq_pkg::*;
  logic          clk_sys_in = 1'b0;
  logic          reset_n_in = 1'b0;
  logic          instr_valid_in = 1'b0;
  op_type        instr_op_in = OP_NONE;
  logic [1:0]    instr_len_in = 2'h1;
  logic [10:0]   instr_imm_in = 11'h000;
  logic [7:0]    instr_byte2_in = 8'h00;
  addr_mode_type instr_mode_in = MODE_DIRECT;
  step_type      instr_step_in = STEP_NONE;
  logic          branch_condition_flag_in = 1'b0;
  logic          int_accept_in = 1'b0;
  logic [5:0]    int_vector_in = 6'h15;
  logic [3:0]    flags_in = 4'hA;
  logic [3:0]    acc_in = 4'h0;
  logic          first_timer_wr_in = 1'b0;
  logic          second_timer_wr_in = 1'b0;
  logic [11:0]   first_timer_value_in = 12'h5A3;
  logic [11:0]   second_timer_value_in = 12'h1C7;
  logic [7:0]    table_data_in;
  logic [7:0]    exp_byte;
  logic [10:0]   prog_addr_out, table_addr_out;
  logic [10:0]   small_prog_addr, small_table_addr;
  logic          acc_load_out, flags_restore_out, port_bit_strobe_out;
  logic [3:0]    acc_data_out, flags_data_out, page_select_out, word_select_out;
  logic [3:0]    port_bit_select_out;
  logic [11:0]   first_timer_count_out, second_timer_count_out;
  int            err_count = 0;
  int            samples_checked = 0;

  program_sequencer i_program_sequencer (
    .clk_sys_in, .reset_n_in, .instr_valid_in, .instr_op_in, .instr_len_in, .instr_imm_in,
    .instr_byte2_in, .instr_mode_in, .instr_step_in, .branch_condition_flag_in,
    .int_accept_in, .int_vector_in, .flags_in, .acc_in, .table_data_in, .first_timer_wr_in,
    .first_timer_value_in, .second_timer_wr_in, .second_timer_value_in, .prog_addr_out,
    .table_addr_out, .acc_load_out, .acc_data_out, .flags_restore_out, .flags_data_out,
    .page_select_out, .word_select_out, .port_bit_strobe_out, .port_bit_select_out,
    .first_timer_count_out, .second_timer_count_out
  );
  program_sequencer #(.SMALL_VARIANT(1'b1)) i_program_sequencer_small (
    .clk_sys_in, .reset_n_in, .instr_valid_in, .instr_op_in, .instr_len_in, .instr_imm_in,
    .instr_byte2_in, .instr_mode_in, .instr_step_in, .branch_condition_flag_in,
    .int_accept_in, .int_vector_in, .flags_in, .acc_in, .table_data_in, .first_timer_wr_in,
    .first_timer_value_in, .second_timer_wr_in, .second_timer_value_in,
    .prog_addr_out(small_prog_addr), .table_addr_out(small_table_addr), .acc_load_out(),
    .acc_data_out(), .flags_restore_out(), .flags_data_out(), .page_select_out(),
    .word_select_out(), .port_bit_strobe_out(), .port_bit_select_out(),
    .first_timer_count_out(), .second_timer_count_out()
  );
  program_memory_model i_program_memory_model (
    .table_addr_in(table_addr_out),
    .table_data_out(table_data_in)
  );

  always #50 clk_sys_in = ~clk_sys_in;

  task automatic complete_run;
    if (err_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // present one instruction; it is taken at the next rising edge
  task automatic exec(input op_type o, input logic [10:0] i, input logic [7:0] b);
    instr_op_in = o;
    instr_imm_in = i;
    instr_byte2_in = b;
    instr_valid_in = 1'b1;
    @(negedge clk_sys_in);
  endtask

  task automatic idle;
    instr_valid_in = 1'b0;
    @(negedge clk_sys_in);
  endtask

  task automatic mem(input op_type o, input logic [7:0] a, input logic [3:0] d);
    instr_mode_in = MODE_DIRECT;
    instr_step_in = STEP_NONE;
    acc_in = d;
    exec(o, 11'h000, a);
  endtask

  task automatic jump(input logic [10:0] t);
    branch_condition_flag_in = 1'b1;
    exec(OP_LONG_BRANCH, t, 8'h00);
  endtask

  task automatic t_flow;
    `CHK("reset addr", 11'h000, prog_addr_out)
    exec(OP_NONE, 11'h000, 8'h00);
    instr_len_in = 2'h2;
    exec(OP_NONE, 11'h000, 8'h00);
    `CHK("length step", 11'h003, prog_addr_out)
    jump(11'h0BF);
    `CHK("long taken", 11'h0BF, prog_addr_out)
    exec(OP_IN_PAGE_BRANCH, 11'h00A, 8'h00);
    `CHK("last in page", 11'h0CA, prog_addr_out)
    exec(OP_IN_PAGE_BRANCH, 11'h03E, 8'h00);
    `CHK("in page", 11'h0FE, prog_addr_out)
    branch_condition_flag_in = 1'b0;
    exec(OP_IN_PAGE_BRANCH, 11'h000, 8'h00);
    `CHK("short skip", 11'h0FF, prog_addr_out)
    exec(OP_LONG_BRANCH, 11'h000, 8'h00);
    `CHK("long skip", 11'h101, prog_addr_out)
    idle();
  endtask

  task automatic t_call;
    mem(OP_MEM_WRITE, 8'h7F, 4'hC);
    jump(11'h4A0);
    `CHK("small fetch", 11'h0A0, small_prog_addr)
    exec(OP_CALL, 11'h345, 8'h00);
    `CHK("call", 11'h345, prog_addr_out)
    exec(OP_SUB_RETURN, 11'h000, 8'h00);
    `CHK("return", 11'h4A2, prog_addr_out)
    mem(OP_MEM_READ, 8'h7F, 4'h0);
    `CHK("selector", 4'hC, acc_data_out)
    mem(OP_MEM_READ, 8'h71, 4'h0);
    `CHK("saved mid nibble", 4'hA, acc_data_out)
    jump(11'h300);
    int_accept_in = 1'b1;
    exec(OP_CALL, 11'h155, 8'h00);
    int_accept_in = 1'b0;
    `CHK("vector", 11'h015, prog_addr_out)
    exec(OP_INT_RETURN, 11'h000, 8'h00);
    `CHK("int return", 11'h300, prog_addr_out)
    `CHK("flag pulse", 1'b1, flags_restore_out)
    `CHK("flag value", 4'hA, flags_data_out)
    idle();
  endtask

  task automatic t_table;
    mem(OP_MEM_WRITE, 8'h7C, 4'hF);
    mem(OP_MEM_WRITE, 8'h7D, 4'hF);
    mem(OP_MEM_WRITE, 8'h7E, 4'h3);
    `CHK("table ptr", 11'h3FF, table_addr_out)
    exp_byte = 8'hFF ^ {3'h3, 5'h0A};
    exec(OP_TABLE_READ_LOW, 11'h000, 8'h00);
    `CHK("low nibble", exp_byte[3:0], acc_data_out)
    `CHK("acc load", 1'b1, acc_load_out)
    `CHK("ptr kept", 11'h3FF, table_addr_out)
    exec(OP_TABLE_READ_HIGH, 11'h000, 8'h00);
    `CHK("high nibble", exp_byte[7:4], acc_data_out)
    `CHK("ptr carry", 11'h400, table_addr_out)
    `CHK("small table", 11'h000, small_table_addr)
    idle();
  endtask

  task automatic t_data;
    exec(OP_LOAD_POINTER_PAIR, 11'h000, 8'h2E);
    `CHK("pair", 8'h2E, {page_select_out, word_select_out})
    instr_mode_in = MODE_INDIRECT;
    instr_step_in = STEP_DEC;
    acc_in = 4'h9;
    exec(OP_MEM_WRITE, 11'h000, 8'h00);
    `CHK("post dec", 4'hD, word_select_out)
    instr_step_in = STEP_INC;
    exec(OP_MEM_WRITE, 11'h000, 8'h00);
    exec(OP_PORT_BIT, 11'h000, 8'h00);
    `CHK("port strobe", 1'b1, port_bit_strobe_out)
    `CHK("port bit", 4'hE, port_bit_select_out)
    mem(OP_MEM_READ, 8'h2E, 4'h0);
    `CHK("direct read", 4'h9, acc_data_out)
    instr_mode_in = MODE_ZERO_PAGE;
    acc_in = 4'h6;
    exec(OP_MEM_WRITE, 11'h000, 8'hF3);
    mem(OP_MEM_READ, 8'h03, 4'h0);
    `CHK("zero page", 4'h6, acc_data_out)
    first_timer_wr_in = 1'b1;
    second_timer_wr_in = 1'b1;
    idle();
    first_timer_wr_in = 1'b0;
    second_timer_wr_in = 1'b0;
    `CHK("timer one", 12'h5A3, first_timer_count_out)
    mem(OP_MEM_READ, 8'h74, 4'h0);
    `CHK("timer word", 4'h3, acc_data_out)
    mem(OP_MEM_WRITE, 8'h7A, 4'hE);
    `CHK("timer two", 12'hEC7, second_timer_count_out)
    mem(OP_MEM_WRITE, 8'h3F, 4'h5);
    mem(OP_MEM_READ, 8'h7F, 4'h0);
    `CHK("upper words", 4'hC, acc_data_out)
    idle();
  endtask

  initial begin
    repeat (16) @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    @(negedge clk_sys_in);
    t_flow();
    t_call();
    t_table();
    t_data();
    complete_run();
  end

  // about 55 cycles including reset; cut a hang after 2000
  initial begin
    #200000;
    err_count++;
    complete_run();
  end
endmodule
